// >>> inc/clock_net_regs.svh
// Purpose: Constants for the clock divide and select network.
// Assumes: One 100 MHz reference clock samples every clock-like input.
// Notes:   Counts, widths and reset values live here as macros.
`ifndef CLOCK_NET_REGS_SVH
`define CLOCK_NET_REGS_SVH

// ----------------------------------------------------------------------
// Counts and widths
// ----------------------------------------------------------------------
`define PDIV_NUM    2
`define FEED_MUXES  4
`define DCS_NUM     2
`define EDIV_NUM    12
`define PLL_OUTS    6
`define SRC_NUM     50
`define FEED_NUM    64
`define DOMAINS     4
`define TRUNKS      16
`define PIN_NUM     64

// ----------------------------------------------------------------------
// Edge counts per output period and reset values
// ----------------------------------------------------------------------
`define EDIV_P_2    9'h004
`define EDIV_P_3P5  9'h007
`define EDIV_P_4    9'h008
`define EDIV_P_5    9'h00a
`define PLL_P_MAX   9'h100
`define CNT_RST     8'h00
`define LVL_RST     1'b0

`endif

// >>> inc/clock_net_pkg.sv
// Purpose: Types shared by the clock divide and select network.
// Assumes: Constants come from clock_net_regs.svh.
// Notes:   Control groups travel as packed structs.
package clock_net_pkg;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PDIV_BYPASS, PDIV_2, PDIV_4, PDIV_8,
        PDIV_16, PDIV_32, PDIV_64, PDIV_128
    } pdiv_ratio_t;

    typedef enum logic [1:0] {EDIV_2, EDIV_3P5, EDIV_4, EDIV_5} ediv_ratio_t;

    typedef enum logic [1:0] {
        ESRC_PLL, ESRC_PIN, ESRC_DELAY, ESRC_ROUTE
    } ediv_src_t;

    typedef enum {SEL_RUN, SEL_DRAIN, SEL_ARM} sel_state_t;

    // ------------------------------------------------------------------
    // Control groups
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rst;
        logic [1:0]  feed;
        pdiv_ratio_t ratio;
    } pdiv_ctl_t;

    typedef struct packed {
        logic        rst;
        ediv_src_t   src;
        ediv_ratio_t ratio;
    } ediv_ctl_t;

    typedef struct packed {
        logic       sel;
        logic       glitchless;
        logic [5:0] alt;
    } dcs_ctl_t;

    typedef struct packed {
        logic       dir_sel;
        logic       dir;
        logic       rotate;
        logic       load;
        logic [2:0] out_sel;
    } phase_ctl_t;

endpackage : clock_net_pkg

// >>> src/clock_divide_select_network.sv
// Purpose: Clock dividers, selectors, gates and trunk muxes, modelled
//          as levels sampled on the reference clock.
// Assumes: Clock-like pins toggle slower than ref_clk; fabric controls
//          are on ref_clk.
// Notes:   Each divider counts both edges of its input level.
`timescale 1ns/1ps
`include "clock_net_regs.svh"

module clock_divide_select_network (
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  wire logic [`SRC_NUM-1:0]           src_pin,
    input  wire logic [`EDIV_NUM-1:0]          edge_pin,
    input  wire logic                          vco_pin,
    input  wire logic                          lock_pin,
    input  wire logic [`FEED_MUXES-1:0][5:0]   feed_sel,
    input  clock_net_pkg::pdiv_ctl_t [`PDIV_NUM-1:0] pdiv_ctl,
    input  clock_net_pkg::ediv_ctl_t [`EDIV_NUM-1:0] ediv_ctl,
    input  clock_net_pkg::dcs_ctl_t  [`DCS_NUM-1:0]  dcs_ctl,
    input  wire logic [`SRC_NUM-1:0]           gate_en,
    input  wire logic [`DOMAINS-1:0][`TRUNKS-1:0][5:0] trunk_sel,
    input  wire logic [`PLL_OUTS-1:0][6:0]     pll_div,
    input  wire logic [`PLL_OUTS-1:0][7:0]     phase_init,
    input  clock_net_pkg::phase_ctl_t          phase_ctl,
    output logic      [`PDIV_NUM-1:0]          pdiv_clk,
    output logic      [`EDIV_NUM-1:0]          ediv_clk,
    output logic      [`DCS_NUM-1:0]           dcs_clk,
    output logic      [`DOMAINS-1:0][`TRUNKS-1:0] trunk_clk,
    output logic      [`PLL_OUTS-1:0]          pll_clk,
    output logic                               lock
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Advances an edge counter that wraps at p edges.
    function automatic logic [7:0] div_step(input logic [7:0] c,
                                            input logic       e,
                                            input logic [8:0] p);
        logic [8:0] n;
        n = {1'b0, c} + 9'h001;
        if (!e)
            div_step = c;
        else if (n >= p)
            div_step = `CNT_RST;
        else
            div_step = n[7:0];
    endfunction : div_step

    // Output is high for the first half of the period, rounded up.
    function automatic logic div_high(input logic [7:0] c,
                                      input logic [8:0] p);
        logic [8:0] h;
        h = (p + 9'h001) >> 1;
        div_high = ({1'b0, c} < h);
    endfunction : div_high

    // ------------------------------------------------------------------
    // Pin synchronisers and slave delay line
    // ------------------------------------------------------------------
    logic [`PIN_NUM-1:0]  s1_r, s2_r, s3_r, f_r;
    logic [`PIN_NUM-1:0]  s1_nxt, s2_nxt, s3_nxt, f_nxt;
    logic [`EDIV_NUM-1:0] dly_r, dly_nxt;
    logic [`SRC_NUM-1:0]  src_f;
    logic [`EDIV_NUM-1:0] edge_f;
    logic                 vco_f;
    logic [`FEED_NUM-1:0] src_pad;

    // A pin level is taken once the second and third stages agree.
    always_comb begin
        s1_nxt  = {lock_pin, vco_pin, edge_pin, src_pin};
        s2_nxt  = s1_r;
        s3_nxt  = s2_r;
        f_nxt   = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & f_r);
        dly_nxt = f_r[`SRC_NUM +: `EDIV_NUM];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            f_r   <= '0;
            dly_r <= '0;
        end else begin
            s1_r  <= s1_nxt;
            s2_r  <= s2_nxt;
            s3_r  <= s3_nxt;
            f_r   <= f_nxt;
            dly_r <= dly_nxt;
        end
    end

    // Filtered pin groups; lock is a plain level, unrelated to outputs.
    assign src_f   = f_r[`SRC_NUM-1:0];
    assign edge_f  = f_r[`SRC_NUM +: `EDIV_NUM];
    assign vco_f   = f_r[`PIN_NUM-2];
    assign lock    = f_r[`PIN_NUM-1];
    assign src_pad = {{(`FEED_NUM-`SRC_NUM){1'b0}}, src_f};

    // ------------------------------------------------------------------
    // Divider feed muxes
    // ------------------------------------------------------------------
    logic [`FEED_MUXES-1:0] feed_clk;

    // Each feed mux picks one routed source for the primary dividers.
    always_comb begin
        for (int k = 0; k < `FEED_MUXES; k++) begin
            feed_clk[k] = src_pad[feed_sel[k]];
        end
    end

    // ------------------------------------------------------------------
    // Primary clock dividers
    // ------------------------------------------------------------------
    for (genvar gi = 0; gi < `PDIV_NUM; gi++) begin : g_pdiv
        logic [7:0] cnt_r, cnt_nxt;
        logic       prev_r, prev_nxt, out_r, out_nxt, x;
        logic [8:0] p;

        // Period is twice the ratio in edges; bypass gives two edges.
        always_comb begin
            x        = feed_clk[pdiv_ctl[gi].feed];
            p        = 9'h002 << pdiv_ctl[gi].ratio;
            prev_nxt = x;
            if (pdiv_ctl[gi].rst)
                cnt_nxt = `CNT_RST;
            else
                cnt_nxt = div_step(cnt_r, x ^ prev_r, p);
            out_nxt  = !pdiv_ctl[gi].rst && div_high(cnt_nxt, p);
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt_r  <= `CNT_RST;
                prev_r <= `LVL_RST;
                out_r  <= `LVL_RST;
            end else begin
                cnt_r  <= cnt_nxt;
                prev_r <= prev_nxt;
                out_r  <= out_nxt;
            end
        end

        // Reset gates the output low in the same cycle it rises.
        assign pdiv_clk[gi] = out_r & ~pdiv_ctl[gi].rst;
    end

    // ------------------------------------------------------------------
    // Synthesizer output dividers with phase control
    // ------------------------------------------------------------------
    for (genvar gi = 0; gi < `PLL_OUTS; gi++) begin : g_pll
        logic [7:0] cnt_r, cnt_nxt;
        logic       prev_r, prev_nxt, out_r, out_nxt, hit, e;
        logic [8:0] p;

        // A zero divide value stands for 128.
        always_comb begin
            p        = (pll_div[gi] == 7'h00) ? `PLL_P_MAX
                                              : {1'b0, pll_div[gi], 1'b0};
            hit      = phase_ctl.dir_sel && (phase_ctl.out_sel == 3'(gi));
            e        = vco_f ^ prev_r;
            prev_nxt = vco_f;
            if (hit && phase_ctl.load)
                cnt_nxt = phase_init[gi];
            else if (hit && phase_ctl.rotate && phase_ctl.dir)
                cnt_nxt = div_step(div_step(cnt_r, 1'b1, p), e, p);
            else if (hit && phase_ctl.rotate)
                cnt_nxt = cnt_r;
            else
                cnt_nxt = div_step(cnt_r, e, p);
            out_nxt  = div_high(cnt_nxt, p);
        end

        // Reset loads the configured phase offset.
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt_r  <= phase_init[gi];
                prev_r <= `LVL_RST;
                out_r  <= `LVL_RST;
            end else begin
                cnt_r  <= cnt_nxt;
                prev_r <= prev_nxt;
                out_r  <= out_nxt;
            end
        end

        assign pll_clk[gi] = out_r;
    end

    // ------------------------------------------------------------------
    // Edge clock dividers
    // ------------------------------------------------------------------
    for (genvar gi = 0; gi < `EDIV_NUM; gi++) begin : g_ediv
        logic [7:0] cnt_r, cnt_nxt;
        logic       prev_r, prev_nxt, out_r, out_nxt, x;
        logic [8:0] p;

        // Source choice; the delayed pin lags the direct one a cycle.
        always_comb begin
            case (ediv_ctl[gi].src)
                clock_net_pkg::ESRC_PLL:   x = pll_clk[gi % `PLL_OUTS];
                clock_net_pkg::ESRC_PIN:   x = edge_f[gi];
                clock_net_pkg::ESRC_DELAY: x = dly_r[gi];
                clock_net_pkg::ESRC_ROUTE: x = src_f[gi];
                default:                   x = 1'b0;
            endcase
            case (ediv_ctl[gi].ratio)
                clock_net_pkg::EDIV_2:   p = `EDIV_P_2;
                clock_net_pkg::EDIV_3P5: p = `EDIV_P_3P5;
                clock_net_pkg::EDIV_4:   p = `EDIV_P_4;
                clock_net_pkg::EDIV_5:   p = `EDIV_P_5;
                default:                 p = `EDIV_P_2;
            endcase
            prev_nxt = x;
            if (ediv_ctl[gi].rst)
                cnt_nxt = `CNT_RST;
            else
                cnt_nxt = div_step(cnt_r, x ^ prev_r, p);
            out_nxt  = !ediv_ctl[gi].rst && div_high(cnt_nxt, p);
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt_r  <= `CNT_RST;
                prev_r <= `LVL_RST;
                out_r  <= `LVL_RST;
            end else begin
                cnt_r  <= cnt_nxt;
                prev_r <= prev_nxt;
                out_r  <= out_nxt;
            end
        end

        assign ediv_clk[gi] = out_r & ~ediv_ctl[gi].rst;
    end

    // ------------------------------------------------------------------
    // Dynamic clock selectors
    // ------------------------------------------------------------------
    for (genvar gi = 0; gi < `DCS_NUM; gi++) begin : g_dcs
        clock_net_pkg::sel_state_t st_r, st_nxt;
        logic       cur_r, cur_nxt, out_r, out_nxt;
        logic [1:0] inp;

        // Input 0 is the divider, input 1 any other routed source.
        always_comb begin
            inp     = {src_pad[dcs_ctl[gi].alt], pdiv_clk[gi]};
            st_nxt  = st_r;
            cur_nxt = cur_r;
            case (st_r)
                clock_net_pkg::SEL_RUN: begin
                    if (dcs_ctl[gi].sel != cur_r) begin
                        if (dcs_ctl[gi].glitchless)
                            st_nxt = clock_net_pkg::SEL_DRAIN;
                        else
                            cur_nxt = dcs_ctl[gi].sel;
                    end
                end
                clock_net_pkg::SEL_DRAIN: begin
                    if (!inp[cur_r]) begin
                        cur_nxt = dcs_ctl[gi].sel;
                        st_nxt  = clock_net_pkg::SEL_ARM;
                    end
                end
                clock_net_pkg::SEL_ARM: begin
                    cur_nxt = dcs_ctl[gi].sel;
                    if (!inp[dcs_ctl[gi].sel])
                        st_nxt = clock_net_pkg::SEL_RUN;
                end
                default: st_nxt = clock_net_pkg::SEL_RUN;
            endcase
            // A draining selector never lets the old clock rise again.
            if (st_nxt == clock_net_pkg::SEL_ARM ||
                (st_nxt == clock_net_pkg::SEL_DRAIN && !out_r))
                out_nxt = 1'b0;
            else
                out_nxt = inp[cur_nxt];
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                st_r  <= clock_net_pkg::SEL_RUN;
                cur_r <= `LVL_RST;
                out_r <= `LVL_RST;
            end else begin
                st_r  <= st_nxt;
                cur_r <= cur_nxt;
                out_r <= out_nxt;
            end
        end

        assign dcs_clk[gi] = out_r;
    end

    // ------------------------------------------------------------------
    // Clock gate elements
    // ------------------------------------------------------------------
    logic [`SRC_NUM-1:0] gen_r, gen_nxt, gated_r, gated_nxt;

    // Enable changes only while the source is low, so no runt pulses.
    always_comb begin
        gen_nxt   = (~f_nxt[`SRC_NUM-1:0] & gate_en)
                  | (f_nxt[`SRC_NUM-1:0] & gen_r);
        gated_nxt = f_nxt[`SRC_NUM-1:0] & gen_nxt;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gen_r   <= '0;
            gated_r <= '0;
        end else begin
            gen_r   <= gen_nxt;
            gated_r <= gated_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Center trunk muxes
    // ------------------------------------------------------------------
    logic [`FEED_NUM-1:0] feeds;
    logic [`DOMAINS-1:0][`TRUNKS-1:0] trunk_r, trunk_nxt;

    // Bottom mid mux carries the edge dividers; 64 feeds in all.
    assign feeds = {gated_r, ediv_clk, dcs_clk};

    // Every trunk line of every domain picks one of the feeds.
    always_comb begin
        for (int d = 0; d < `DOMAINS; d++) begin
            for (int t = 0; t < `TRUNKS; t++) begin
                trunk_nxt[d][t] = feeds[trunk_sel[d][t]];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            trunk_r <= '0;
        else
            trunk_r <= trunk_nxt;
    end

    assign trunk_clk = trunk_r;

endmodule : clock_divide_select_network

// >>> bench/clock_net_asserts.sv
// Purpose: Port-level checks for the clock divide and select network.
// Assumes: Watched signals are levels sampled on ref_clk.
// Notes:   Divider 0, selector 0 and a few trunks are watched; the reset check covers all outputs but pll_clk.
`timescale 1ns/1ps
`include "clock_net_regs.svh"

module clock_net_asserts (
    input  wire logic                                ref_clk,
    input  wire logic                                reset,
    input  wire logic                                lock_pin,
    input  clock_net_pkg::pdiv_ctl_t [`PDIV_NUM-1:0] pdiv_ctl,
    input  clock_net_pkg::ediv_ctl_t [`EDIV_NUM-1:0] ediv_ctl,
    input  clock_net_pkg::dcs_ctl_t  [`DCS_NUM-1:0]  dcs_ctl,
    input  wire logic [`SRC_NUM-1:0]                 gate_en,
    input  wire logic [`DOMAINS-1:0][`TRUNKS-1:0][5:0] trunk_sel,
    input  wire logic [`PDIV_NUM-1:0]                pdiv_clk,
    input  wire logic [`EDIV_NUM-1:0]                ediv_clk,
    input  wire logic [`DCS_NUM-1:0]                 dcs_clk,
    input  wire logic [`DOMAINS-1:0][`TRUNKS-1:0]    trunk_clk,
    input  wire logic                                lock
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_pdiv_rst;
        pdiv_ctl[0].rst |-> !pdiv_clk[0];
    endproperty
    a_pdiv_rst: assert property (p_pdiv_rst)
        else $error("primary divider high while held in reset");

    property p_ediv_rst;
        ediv_ctl[0].rst |-> !ediv_clk[0];
    endproperty
    a_ediv_rst: assert property (p_ediv_rst)
        else $error("edge divider high while held in reset");

    property p_rst_out;
        disable iff (1'b0)
        reset |=> (pdiv_clk == '0 && ediv_clk == '0 && dcs_clk == '0
                   && trunk_clk == '0 && !lock);
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not low after network reset");

    property p_pdiv_start;
        $fell(pdiv_ctl[0].rst) && pdiv_ctl[0].ratio != clock_net_pkg::PDIV_BYPASS
        |-> ##[0:1] pdiv_clk[0];
    endproperty
    a_pdiv_start: assert property (p_pdiv_start)
        else $error("primary divider did not restart after release");

    property p_dcs_plain;
        (!dcs_ctl[0].sel && !dcs_ctl[0].glitchless)[*2]
        |-> dcs_clk[0] == $past(pdiv_clk[0]);
    endproperty
    a_dcs_plain: assert property (p_dcs_plain)
        else $error("plain selector does not follow divider input");

    property p_dcs_rise;
        dcs_ctl[0].glitchless && !dcs_ctl[0].sel && $rose(dcs_clk[0])
        |-> $past(pdiv_clk[0]);
    endproperty
    a_dcs_rise: assert property (p_dcs_rise)
        else $error("selector output rose without its source");

    property p_trunk0;
        (trunk_sel[0][0] == 6'h00)[*2] |-> trunk_clk[0][0] == $past(dcs_clk[0]);
    endproperty
    a_trunk0: assert property (p_trunk0)
        else $error("trunk does not carry selector clock");

    sequence s_gated;
        !gate_en[0] && trunk_sel[1][0] == 6'h0e;
    endsequence
    property p_gate;
        s_gated[*8] ##1 s_gated[*4] |-> !trunk_clk[1][0];
    endproperty
    a_gate: assert property (p_gate)
        else $error("disabled clock still toggles on trunk");

    property p_lock;
        $stable(lock_pin)[*8] |-> lock == lock_pin;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock flag does not follow settled lock level");

    // Main scenarios seen at least once.
    c_restart: cover property ($fell(pdiv_ctl[0].rst));
    c_switch: cover property (dcs_ctl[0].glitchless && $changed(dcs_ctl[0].sel));
    c_lock: cover property ($rose(lock));
endmodule : clock_net_asserts

// >>> bench/fabric_model.sv
// Purpose: Fabric-side model that feeds clocks and takes the lock flag.
// Assumes: Driven pins change on the falling ref_clk edge.
// Notes:   Sources never stop, even during reset.
`timescale 1ns/1ps
`include "clock_net_regs.svh"

module fabric_model (
    input  wire logic            ref_clk,
    input  wire logic            lock,
    output logic [`SRC_NUM-1:0]  src_pin,
    output logic [`EDIV_NUM-1:0] edge_pin,
    output logic                 vco_pin,
    output logic                 lock_sync
);
    logic [7:0] cnt_r = 8'h00;
    logic [1:0] sync_r = 2'h0;

    // Free-running count; odd sources run at half the even rate.
    always @(negedge ref_clk) begin
        cnt_r <= cnt_r + 8'h01;
    end

    // Every source keeps toggling so a glitchless switch can finish.
    always_comb begin
        for (int i = 0; i < `SRC_NUM; i++) begin
            src_pin[i] = (i % 2 == 1) ? cnt_r[2] : cnt_r[1];
        end
        edge_pin = {`EDIV_NUM{cnt_r[1]}};
        vco_pin  = cnt_r[1];
    end

    // Two flops bring the lock flag into the fabric domain before use.
    always @(posedge ref_clk) begin
        sync_r <= {sync_r[0], lock};
    end
    assign lock_sync = sync_r[1];
endmodule : fabric_model

// >>> bench/tb_top.sv
// Purpose: Directed bench for the clock divide and select network.
// Assumes: Periods are counted in ref_clk cycles, sampled after edges.
// Notes:   Expected periods follow from the fabric model's source rates.
`timescale 1ns/1ps
`include "clock_net_regs.svh"

module tb_top;
    logic                                     ref_clk = 1'b0;
    logic                                     reset = 1'b1;
    logic                                     lock_pin = 1'b0;
    logic [`SRC_NUM-1:0]                      src_pin;
    logic [`EDIV_NUM-1:0]                     edge_pin;
    logic                                     vco_pin;
    logic                                     lock_sync;
    logic [`FEED_MUXES-1:0][5:0]              feed_sel = '0;
    clock_net_pkg::pdiv_ctl_t [`PDIV_NUM-1:0] pdiv_ctl = '0;
    clock_net_pkg::ediv_ctl_t [`EDIV_NUM-1:0] ediv_ctl = '0;
    clock_net_pkg::dcs_ctl_t  [`DCS_NUM-1:0]  dcs_ctl = '0;
    logic [`SRC_NUM-1:0]                      gate_en = '1;
    logic [`DOMAINS-1:0][`TRUNKS-1:0][5:0]    trunk_sel = '0;
    logic [`PLL_OUTS-1:0][6:0]                pll_div = {`PLL_OUTS{7'h03}};
    logic [`PLL_OUTS-1:0][7:0]                phase_init = '0;
    clock_net_pkg::phase_ctl_t                phase_ctl = '0;
    logic [`PDIV_NUM-1:0]                     pdiv_clk;
    logic [`EDIV_NUM-1:0]                     ediv_clk;
    logic [`DCS_NUM-1:0]                      dcs_clk;
    logic [`DOMAINS-1:0][`TRUNKS-1:0]         trunk_clk;
    logic [`PLL_OUTS-1:0]                     pll_clk;
    logic                                     lock;
    logic                                     watch;
    int pick = 0;
    int checked = 0;
    int err_total = 0;
    int cycles = 0;
    int per, hi, k;
    int ep[4] = '{8, 14, 16, 20};
    int eh[4] = '{4, 8, 8, 10};
    int es[4] = '{24, 8, 8, 8};
    int pn[3] = '{1, 5, 0};
    int px[3] = '{4, 20, 512};

    clock_divide_select_network uut (.ref_clk, .reset, .src_pin, .edge_pin,
        .vco_pin, .lock_pin, .feed_sel, .pdiv_ctl, .ediv_ctl, .dcs_ctl,
        .gate_en, .trunk_sel, .pll_div, .phase_init, .phase_ctl, .pdiv_clk,
        .ediv_clk, .dcs_clk, .trunk_clk, .pll_clk, .lock);
    fabric_model fab (.ref_clk, .lock, .src_pin, .edge_pin, .vco_pin,
        .lock_sync);

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;

    // A hang counts as a mismatch and ends the run.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            results();
        end
    end

    // One clock output is chosen for period measurement.
    always_comb begin
        case (pick)
            0: watch = pdiv_clk[0];
            1: watch = ediv_clk[0];
            2: watch = dcs_clk[0];
            3: watch = pll_clk[0];
            4: watch = trunk_clk[0][0];
            5: watch = trunk_clk[1][0];
            default: watch = trunk_clk[3][15];
        endcase
    end

    task automatic tick(inout int n);
        @(posedge ref_clk);
        #1;
        n++;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Ends on a rising sample; gives high time and full period.
    task automatic meas(input int p, output int per_o, output int hi_o);
        int n = 0;
        int r;
        pick = p;
        tick(n);
        while (watch !== 1'b0 && n < 2000) tick(n);
        while (watch !== 1'b1 && n < 2000) tick(n);
        r = n;
        while (watch === 1'b1 && n < 2000) tick(n);
        hi_o = n - r;
        while (watch === 1'b0 && n < 2000) tick(n);
        per_o = n - r;
    endtask : meas

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Directed sequence
    // ------------------------------------------------------------------
    initial begin
        dcs_ctl[0].alt = 6'h01;
        ediv_ctl[0].src = clock_net_pkg::ESRC_PIN;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) reset = 1'b0;
        repeat (10) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk) pdiv_ctl[0].ratio = clock_net_pkg::pdiv_ratio_t'(i);
            meas(0, per, hi);
            meas(0, per, hi);
            chk(per, (i == 0) ? 4 : (4 << i));
            chk(hi, (i == 0) ? 2 : (2 << i));
        end
        @(negedge ref_clk) pdiv_ctl[0].ratio = clock_net_pkg::PDIV_4;
        pdiv_ctl[0].rst = 1'b1;
        ediv_ctl[0].rst = 1'b1;
        #1 chk(pdiv_clk[0], 1'b0);
        chk(ediv_clk[0], 1'b0);
        repeat (3) @(negedge ref_clk);
        pdiv_ctl[0].rst = 1'b0;
        ediv_ctl[0].rst = 1'b0;
        @(posedge ref_clk) #1 chk(pdiv_clk[0], 1'b1);
        meas(0, per, hi);
        chk(per, 16);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) ediv_ctl[0].ratio = clock_net_pkg::ediv_ratio_t'(i);
            meas(1, per, hi);
            meas(1, per, hi);
            chk(per, ep[i]);
            chk(hi, eh[i]);
        end
        @(negedge ref_clk) ediv_ctl[0].ratio = clock_net_pkg::EDIV_2;
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) ediv_ctl[0].src = clock_net_pkg::ediv_src_t'(i);
            meas(1, per, hi);
            meas(1, per, hi);
            chk(per, es[i]);
        end
        @(negedge ref_clk) pdiv_ctl[0].ratio = clock_net_pkg::PDIV_BYPASS;
        for (int g = 0; g < 2; g++) begin
            @(negedge ref_clk) dcs_ctl[0].glitchless = g[0];
            dcs_ctl[0].sel = 1'b1;
            meas(2, per, hi);
            meas(2, per, hi);
            chk(per, 8);
            @(negedge ref_clk) dcs_ctl[0].sel = 1'b0;
            meas(2, per, hi);
            meas(2, per, hi);
            chk(per, 4);
        end
        meas(4, per, hi);
        chk(per, 4);
        @(negedge ref_clk) trunk_sel[1][0] = 6'h0e;
        trunk_sel[3][15] = 6'h3f;
        gate_en[0] = 1'b0;
        repeat (12) @(negedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk) #1 chk(trunk_clk[1][0], 1'b0);
        end
        @(negedge ref_clk) gate_en[0] = 1'b1;
        meas(5, per, hi);
        meas(5, per, hi);
        chk(per, 4);
        meas(6, per, hi);
        chk(per, 8);
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk) pll_div[0] = 7'(pn[i]);
            meas(3, per, hi);
            meas(3, per, hi);
            chk(per, px[i]);
            chk(hi, px[i] / 2);
        end
        @(negedge ref_clk) pll_div[0] = 7'h05;
        for (int d = 0; d < 2; d++) begin
            meas(3, per, hi);
            @(negedge ref_clk) phase_ctl.dir_sel = d[0];
            phase_ctl.dir = 1'b1;
            phase_ctl.rotate = 1'b1;
            @(negedge ref_clk) phase_ctl.rotate = 1'b0;
            k = 1;
            while (watch !== 1'b0 && k < 600) tick(k);
            while (watch !== 1'b1 && k < 600) tick(k);
            chk(k, (d == 1) ? 18 : 20);
        end
        @(negedge ref_clk) lock_pin = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(lock, 1'b1);
        repeat (3) @(negedge ref_clk);
        chk(lock_sync, 1'b1);
        lock_pin = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(lock, 1'b0);
        results();
    end
endmodule : tb_top

bind clock_divide_select_network clock_net_asserts chk_i (.ref_clk, .reset,
    .lock_pin, .pdiv_ctl, .ediv_ctl, .dcs_ctl, .gate_en, .trunk_sel,
    .pdiv_clk, .ediv_clk, .dcs_clk, .trunk_clk, .lock);
